// [shared/timer_trig_regs.svh]
// Register indices, field positions and reset values of the trigger and
// polarity block. Assumes inclusion by bare name from the design files.
`ifndef TIMER_TRIG_REGS_SVH
`define TIMER_TRIG_REGS_SVH

// Register indices; the byte address is four times the index
`define EXT_TRIG_CTRL_IDX        8'h23
`define CHAN_POLARITY_IDX        8'h24

// External trigger control fields
`define TRIG_FLAG_BIT            7
`define INIT_TRIG_EN_BIT         6
`define CHAN1_TRIG_EN_BIT        5
`define CHAN0_TRIG_EN_BIT        4
`define CHAN5_TRIG_EN_BIT        3
`define CHAN4_TRIG_EN_BIT        2
`define CHAN3_TRIG_EN_BIT        1
`define CHAN2_TRIG_EN_BIT        0

// Reset values
`define EXT_TRIG_CTRL_RESET      8'h00
`define CHAN_POLARITY_RESET      8'h00

// Channel counts
`define POLARITY_CHANNELS        8
`define TRIGGER_CHANNELS         6

`endif

// [shared/timer_trig_pkg.sv]
// Types shared by the trigger and polarity block.
// Assumes the register header supplies all numeric constants.
`include "timer_trig_regs.svh"

package timer_trig_pkg;

  // Register selected by an APB address
  typedef enum logic [1:0] {
    SEL_EXT_TRIG,
    SEL_POLARITY,
    SEL_NONE
  } reg_sel_type;

  // Progress of the flag clear sequence
  typedef enum logic {
    CLR_IDLE,
    CLR_ARMED
  } clear_state_type;

  // One cycle of trigger events
  typedef struct packed {
    logic                              init_trig;
    logic [`TRIGGER_CHANNELS-1:0]      chan_trig;
  } trig_event_type;

endpackage

// [hdl/trigger_match.sv]
// Detects counter matches against the initial value and channel compares.
// Assumes counter and compare values come from logic on the same clock.
`timescale 1ns/10ps
`include "timer_trig_regs.svh"

module trigger_match #(
  parameter int CNT_W   = 16,
  parameter int NUM_SRC = `TRIGGER_CHANNELS
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [CNT_W-1:0]         counter_value,
  input  wire logic [CNT_W-1:0]         counter_init_value,
  input  wire logic [NUM_SRC*CNT_W-1:0] channel_compare_value,
  input  wire logic [NUM_SRC-1:0]       chan_enable,
  input  wire logic                     init_trigger_enable,
  output logic      [NUM_SRC-1:0]       chan_hit,
  output logic                          init_hit
);

  // Parameter checks at elaboration
  generate
    if (CNT_W < 1 || NUM_SRC < 1) begin : g_bad_param
      $error("CNT_W and NUM_SRC must be at least 1");
    end
  endgenerate

  logic [NUM_SRC-1:0] chan_eq;
  logic [NUM_SRC-1:0] chan_eq_reg;
  logic               init_eq;
  logic               init_eq_reg;

  // Per channel equality, only on entry to the matching count
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_chan
      assign chan_eq[g] =
        counter_value == channel_compare_value[g*CNT_W +: CNT_W];
      assign chan_hit[g] = chan_enable[g] & chan_eq[g] & ~chan_eq_reg[g];
    end
  endgenerate

  assign init_eq  = counter_value == counter_init_value;
  assign init_hit = init_trigger_enable & init_eq & ~init_eq_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      chan_eq_reg <= '0;
    end else begin
      chan_eq_reg <= chan_eq;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      init_eq_reg <= 1'b0;
    end else begin
      init_eq_reg <= init_eq;
    end
  end

endmodule // trigger_match

// [hdl/timer_trigger_and_polarity.sv]
// Trigger generation, trigger flag and channel output polarity of a timer.
// Assumes an APB master on clk and timer signals from the same clock.
`timescale 1ns/10ps
`include "timer_trig_regs.svh"

module timer_trigger_and_polarity #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 12,
  parameter int NUM_CH = `POLARITY_CHANNELS
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic      [31:0]              prdata,
  output logic                          pslverr,
  // Timer side
  input  wire logic [CNT_W-1:0]         counter_value,
  input  wire logic [CNT_W-1:0]         counter_init_value,
  input  wire logic [`TRIGGER_CHANNELS*CNT_W-1:0] channel_compare_value,
  input  wire logic                     write_protect_disable,
  input  wire logic                     fault_control_enable,
  input  wire logic                     fault_detected,
  input  wire logic [NUM_CH-1:0]        fault_channel_mask,
  input  wire logic [NUM_CH-1:0]        chan_wave,
  // Outputs to consumers and pins
  output timer_trig_pkg::trig_event_type trig_event,
  output logic                          trig_pulse,
  output logic                          trigger_flag,
  output logic      [NUM_CH-1:0]        chan_out
);

  // Parameter checks at elaboration
  generate
    if (NUM_CH != `POLARITY_CHANNELS) begin : g_bad_ch
      $error("NUM_CH must equal the polarity register width");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must lie between 1 and 32");
    end
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 10 and 32");
    end
  endgenerate

  // Address decode shared by the read and write paths
  function automatic timer_trig_pkg::reg_sel_type decode_addr(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] ext_addr;
    logic [ADDR_W-1:0] pol_addr;
    ext_addr = ADDR_W'({`EXT_TRIG_CTRL_IDX, 2'b00});
    pol_addr = ADDR_W'({`CHAN_POLARITY_IDX, 2'b00});
    if (addr == ext_addr) begin
      decode_addr = timer_trig_pkg::SEL_EXT_TRIG;
    end else if (addr == pol_addr) begin
      decode_addr = timer_trig_pkg::SEL_POLARITY;
    end else begin
      decode_addr = timer_trig_pkg::SEL_NONE;
    end
  endfunction

  // Reorders the enable field into channel order 5..0
  function automatic logic [`TRIGGER_CHANNELS-1:0] chan_enables(
    input logic [7:0] ctrl
  );
    logic [`TRIGGER_CHANNELS-1:0] en;
    en    = '0;
    en[0] = ctrl[`CHAN0_TRIG_EN_BIT];
    en[1] = ctrl[`CHAN1_TRIG_EN_BIT];
    en[2] = ctrl[`CHAN2_TRIG_EN_BIT];
    en[3] = ctrl[`CHAN3_TRIG_EN_BIT];
    en[4] = ctrl[`CHAN4_TRIG_EN_BIT];
    en[5] = ctrl[`CHAN5_TRIG_EN_BIT];
    chan_enables = en;
  endfunction

  logic [6:0]                      trig_enable_reg;
  logic                            trig_flag_reg;
  logic [NUM_CH-1:0]               chan_polarity_reg;
  timer_trig_pkg::clear_state_type clr_state_reg;
  logic [31:0]                     prdata_reg;
  logic                            pslverr_reg;
  logic                            flag_seen_reg;
  timer_trig_pkg::trig_event_type  trig_event_reg;
  logic                            trig_pulse_reg;
  logic [NUM_CH-1:0]               chan_out_reg;

  timer_trig_pkg::reg_sel_type     sel;
  logic                            setup_phase;
  logic                            access_done;
  logic                            wr_ext;
  logic                            wr_pol;
  logic                            rd_ext;
  logic                            clear_go;
  logic [7:0]                      ext_read_value;
  logic [`TRIGGER_CHANNELS-1:0]    chan_hit;
  logic                            init_hit;
  logic                            trig_now;
  logic                            fault_active;
  logic [NUM_CH-1:0]               chan_out_next;
  logic [`TRIGGER_CHANNELS-1:0]    chan_trig_enable;

  // Enable field in channel order, used by the match logic
  assign chan_trig_enable = chan_enables({1'b0, trig_enable_reg});

  // Match detection; only channels 0 to 5 have compare inputs
  trigger_match #(
    .CNT_W   (CNT_W),
    .NUM_SRC (`TRIGGER_CHANNELS)
  ) u_match (
    .clk                   (clk),
    .nrst                  (nrst),
    .counter_value         (counter_value),
    .counter_init_value    (counter_init_value),
    .channel_compare_value (channel_compare_value),
    .chan_enable           (chan_trig_enable),
    .init_trigger_enable   (trig_enable_reg[`INIT_TRIG_EN_BIT]),
    .chan_hit              (chan_hit),
    .init_hit              (init_hit)
  );

  // Any trigger source firing this cycle
  assign trig_now = init_hit | (|chan_hit);

  // APB phases; one access cycle, answer always ready
  assign sel         = decode_addr(paddr);
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable;
  assign pready      = psel & penable;
  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg & psel & penable;

  assign wr_ext = access_done & pwrite & pstrb[0] & ~pslverr_reg &
                  (sel == timer_trig_pkg::SEL_EXT_TRIG);
  assign wr_pol = access_done & pwrite & pstrb[0] & ~pslverr_reg &
                  (sel == timer_trig_pkg::SEL_POLARITY);
  assign rd_ext = access_done & ~pwrite &
                  (sel == timer_trig_pkg::SEL_EXT_TRIG);

  assign ext_read_value = {trig_flag_reg, trig_enable_reg};

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      case (sel)
        timer_trig_pkg::SEL_EXT_TRIG: begin
          prdata_reg <= {24'h00_0000, ext_read_value};
        end
        timer_trig_pkg::SEL_POLARITY: begin
          prdata_reg <= {24'h00_0000, chan_polarity_reg};
        end
        default: begin
          prdata_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Flag value seen by the read in progress
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_seen_reg <= 1'b0;
    end else if (setup_phase) begin
      flag_seen_reg <= trig_flag_reg;
    end
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= (sel == timer_trig_pkg::SEL_NONE);
    end
  end

  // Trigger enables, not write protected
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_enable_reg <= 7'(`EXT_TRIG_CTRL_RESET);
    end else if (wr_ext) begin
      trig_enable_reg <= pwdata[6:0];
    end
  end

  // Clear sequence: armed by a read of a set flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clr_state_reg <= timer_trig_pkg::CLR_IDLE;
    end else begin
      case (clr_state_reg)
        timer_trig_pkg::CLR_IDLE: begin
          if (rd_ext && flag_seen_reg && !trig_now) begin
            clr_state_reg <= timer_trig_pkg::CLR_ARMED;
          end
        end
        timer_trig_pkg::CLR_ARMED: begin
          if (trig_now) begin
            clr_state_reg <= timer_trig_pkg::CLR_IDLE;
          end else if (wr_ext) begin
            clr_state_reg <= timer_trig_pkg::CLR_IDLE;
          end
        end
        default: begin
          clr_state_reg <= timer_trig_pkg::CLR_IDLE;
        end
      endcase
    end
  end

  // A write of 1 never clears; a write of 0 clears only when armed
  assign clear_go = wr_ext & ~pwdata[`TRIG_FLAG_BIT] &
                    (clr_state_reg == timer_trig_pkg::CLR_ARMED);

  localparam logic FLAG_RESET = 1'(`EXT_TRIG_CTRL_RESET >> `TRIG_FLAG_BIT);

  // Flag: a trigger in the same cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_flag_reg <= FLAG_RESET;
    end else if (trig_now) begin
      trig_flag_reg <= 1'b1;
    end else if (clear_go) begin
      trig_flag_reg <= 1'b0;
    end
  end

  assign trigger_flag = trig_flag_reg;

  // Trigger pulses for consumers, aligned with the flag setting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_event_reg <= '0;
    end else begin
      trig_event_reg.init_trig <= init_hit;
      trig_event_reg.chan_trig <= chan_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_pulse_reg <= 1'b0;
    end else begin
      trig_pulse_reg <= trig_now;
    end
  end

  assign trig_event = trig_event_reg;
  assign trig_pulse = trig_pulse_reg;

  // Polarity register, guarded by write protection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chan_polarity_reg <= NUM_CH'(`CHAN_POLARITY_RESET);
    end else if (wr_pol && write_protect_disable) begin
      chan_polarity_reg <= pwdata[NUM_CH-1:0];
    end
  end

  assign fault_active = fault_control_enable & fault_detected;

  // Output shaping per channel; a fault with fault_control_enable forces the inactive level on channels set in fault_channel_mask
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_out
      assign chan_out_next[g] = (fault_active && fault_channel_mask[g]) ?
                                chan_polarity_reg[g] :
                                chan_wave[g] ^ chan_polarity_reg[g];
    end
  endgenerate

  // Registered channel outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chan_out_reg <= '0;
    end else begin
      chan_out_reg <= chan_out_next;
    end
  end

  assign chan_out = chan_out_reg;

endmodule // timer_trigger_and_polarity

// [tb/trig_consumer.sv]
// Far side stand-in: an on-chip consumer that counts trigger pulses.
// Assumes the pulses are synchronous to clk.
`timescale 1ns/10ps
module trig_consumer (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic trig_pulse,
  output int        pulse_count
);
  // Each pulse is one event
  always_ff @(posedge clk) begin
    if (!nrst) pulse_count <= 0;
    else if (trig_pulse) pulse_count <= pulse_count + 1;
  end
endmodule // trig_consumer

// [tb/timer_trig_assertions.sv]
// Concurrent checks on the ports of the trigger and polarity block.
// Assumes byte addresses are four times the register indices.
`timescale 1ns/10ps
`include "timer_trig_regs.svh"
module timer_trig_assertions #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 12,
  parameter int NUM_CH = 8
) (
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic                     pready,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  input wire logic [CNT_W-1:0]         counter_value,
  input wire logic [CNT_W-1:0]         counter_init_value,
  input wire logic [`TRIGGER_CHANNELS*CNT_W-1:0] channel_compare_value,
  input wire logic                     fault_control_enable,
  input wire logic                     fault_detected,
  input wire logic [NUM_CH-1:0]        fault_channel_mask,
  input timer_trig_pkg::trig_event_type trig_event,
  input wire logic                     trig_pulse,
  input wire logic                     trigger_flag,
  input wire logic [NUM_CH-1:0]        chan_out
);
  localparam logic [ADDR_W-1:0] EXT_A = ADDR_W'({`EXT_TRIG_CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] POL_A = ADDR_W'({`CHAN_POLARITY_IDX, 2'b00});
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire acc = psel && penable;
  wire ext_wr = acc && pwrite && paddr == EXT_A && pstrb[0];
  wire quiet = fault_control_enable && fault_detected
               && (&fault_channel_mask) && !(acc && pwrite);
  sequence s_fault_held;
    quiet [*3];
  endsequence
  a_pulse_is_or: assert property (trig_pulse == (|trig_event))
    else $error("pulse differs from events");
  a_flag_follows: assert property (trig_pulse |-> trigger_flag)
    else $error("flag not set by trigger");
  a_flag_cause: assert property ($rose(trigger_flag) |-> trig_pulse)
    else $error("flag set without trigger");
  a_one_kept: assert property (ext_wr && pwdata[7] && trigger_flag
    |=> trigger_flag) else $error("write of one cleared flag");
  a_clear_cause: assert property ($fell(trigger_flag)
    |-> $past(ext_wr && !pwdata[7])) else $error("flag fell unasked");
  a_fault_safe: assert property (s_fault_held |=> $stable(chan_out))
    else $error("output moved under fault");
  a_init_cause: assert property (trig_event.init_trig
    |-> $past(counter_value == counter_init_value))
    else $error("init trigger without match");
  a_ch0_cause: assert property (trig_event.chan_trig[0]
    |-> $past(counter_value == channel_compare_value[CNT_W-1:0]))
    else $error("channel trigger without match");
  a_read_upper: assert property (acc && !pwrite
    |-> pready && prdata[31:8] == 24'h00_0000) else $error("bad read");
  a_unmapped_err: assert property (acc && paddr != EXT_A && paddr != POL_A
    |-> pslverr) else $error("no error on unmapped address");
endmodule // timer_trig_assertions

bind timer_trigger_and_polarity timer_trig_assertions #(.CNT_W(CNT_W),
  .ADDR_W(ADDR_W), .NUM_CH(NUM_CH)) u_chk (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .counter_value(counter_value),
  .counter_init_value(counter_init_value),
  .channel_compare_value(channel_compare_value),
  .fault_control_enable(fault_control_enable),
  .fault_detected(fault_detected), .fault_channel_mask(fault_channel_mask),
  .trig_event(trig_event), .trig_pulse(trig_pulse),
  .trigger_flag(trigger_flag), .chan_out(chan_out));

// [tb/timer_trigger_and_polarity_tb.sv]
// Self-checking bench: APB register access, triggers, flag and outputs.
// Assumes zero-wait APB slave and a 20 MHz clock.
`timescale 1ns/10ps
`include "timer_trig_regs.svh"
module timer_trigger_and_polarity_tb;
  localparam logic [11:0] EXT_A = {2'b00, `EXT_TRIG_CTRL_IDX, 2'b00};
  localparam logic [11:0] POL_A = {2'b00, `CHAN_POLARITY_IDX, 2'b00};
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, slv;
  logic        wpd, fce, fdet, trig_pulse, trigger_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] cnt, cnt_init;
  logic [95:0] cmp;
  logic [7:0]  fmask, wave, chan_out;
  timer_trig_pkg::trig_event_type trig_event;
  int          bad_count, num_checks, pulses;

  timer_trigger_and_polarity uut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .counter_value(cnt), .counter_init_value(cnt_init),
    .channel_compare_value(cmp), .write_protect_disable(wpd),
    .fault_control_enable(fce), .fault_detected(fdet),
    .fault_channel_mask(fmask), .chan_wave(wave), .trig_event(trig_event),
    .trig_pulse(trig_pulse), .trigger_flag(trigger_flag),
    .chan_out(chan_out));
  trig_consumer far (.clk(clk), .nrst(nrst), .trig_pulse(trig_pulse),
    .pulse_count(pulses));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      bad_count++;
      $display("unexpected at %0t: no ready", $time);
      report_and_stop();
    end
  endtask

  // Counter visits one value for one cycle, then the events are compared
  task automatic hit(input logic [15:0] v, input logic [6:0] exp);
    @(posedge clk) cnt <= v;
    @(posedge clk) cnt <= 16'h0F00;
    #1 check(32'(trig_event), 32'(exp));
    check(32'(trig_pulse), 32'(|exp));
  endtask

  initial begin
    {nrst, psel, penable, pwrite, wpd, fce, fdet} = '0;
    {paddr, pwdata, fmask, wave, bad_count, num_checks} = '0;
    pstrb = 4'hF;
    cnt = 16'h0F00;
    cnt_init = 16'h0100;
    for (int i = 0; i < 6; i++) cmp[i*16+:16] = 16'h0010 + 16'(i);
    repeat (4) @(posedge clk);
    nrst <= 1;
    apb(0, EXT_A, 0); check(rd, 0);
    apb(0, POL_A, 0); check(rd, 0);
    apb(1, POL_A, 32'h0000_00A5); apb(0, POL_A, 0); check(rd, 0);
    @(posedge clk) wpd <= 1;
    apb(1, POL_A, 32'hFFFF_FFA5); apb(0, POL_A, 0); check(rd, 32'hA5);
    apb(0, 12'h094, 0); check(rd, 0); check(32'(slv), 1);
    @(posedge clk) wave <= 8'h3C;
    repeat (2) @(posedge clk);
    #1 check(32'(chan_out), 32'h99);
    @(posedge clk) {fce, fdet, fmask} <= {2'b11, 8'hF0};
    repeat (2) @(posedge clk);
    #1 check(32'(chan_out), 32'hA9);
    @(posedge clk) fmask <= 8'hFF;
    repeat (4) @(posedge clk) wave <= ~wave;
    #1 check(32'(chan_out), 32'hA5);
    @(posedge clk) fce <= 0;
    for (int i = 0; i < 6; i++) begin
      apb(1, EXT_A, 32'(1) << ((i < 2) ? i + 4 : i - 2));
      hit(cmp[i*16+:16], 7'(1) << i);
    end
    @(posedge clk) cmp <= {6{16'h0020}};
    apb(1, EXT_A, 32'h3F); hit(16'h0020, 7'h3F);
    apb(1, EXT_A, 0); hit(16'h0100, 7'h00);
    apb(1, EXT_A, 32'h40); hit(16'h0100, 7'h40);
    check(32'(trigger_flag), 1);
    apb(0, EXT_A, 0); check(rd, 32'hC0);
    apb(1, EXT_A, 32'hC0); #1 check(32'(trigger_flag), 1);
    apb(1, EXT_A, 32'h40); #1 check(32'(trigger_flag), 1);
    apb(0, EXT_A, 0); apb(1, EXT_A, 32'h40);
    #1 check(32'(trigger_flag), 0);
    hit(16'h0100, 7'h40); apb(0, EXT_A, 0); hit(16'h0100, 7'h40);
    apb(1, EXT_A, 32'h40); #1 check(32'(trigger_flag), 1);
    apb(0, EXT_A, 0); apb(1, EXT_A, 32'h40);
    #1 check(32'(trigger_flag), 0);
    check(32'(pulses), 10);
    report_and_stop();
  end
endmodule // timer_trigger_and_polarity_tb
